/* rtl/dgt_pkg.sv */
// Shared constants and types for the dual general timer block
package dgt_pkg;
    // Register byte addresses
    localparam logic [31:0] DGT_A_LOAD_ADDR = 32'hffff0300;
    localparam logic [31:0] DGT_A_COUNT_ADDR = 32'hffff0304;
    localparam logic [31:0] DGT_A_CTRL_ADDR = 32'hffff0308;
    localparam logic [31:0] DGT_A_CLR_ADDR = 32'hffff030c;
    localparam logic [31:0] DGT_B_LOAD_ADDR = 32'hffff0320;
    localparam logic [31:0] DGT_B_COUNT_ADDR = 32'hffff0324;
    localparam logic [31:0] DGT_B_CTRL_ADDR = 32'hffff0328;
    localparam logic [31:0] DGT_B_CLR_ADDR = 32'hffff032c;
    localparam logic [31:0] DGT_B_CAP_ADDR = 32'hffff0330;
    // Reset values
    localparam logic [15:0] DGT_A_LOAD_RST = 16'h0000;
    localparam logic [15:0] DGT_A_COUNT_RST = 16'hffff;
    localparam logic [31:0] DGT_B_COUNT_RST = 32'h0fffffff;
    localparam logic [31:0] DGT_B_LOAD_RST = 32'h00000000;
    // Timer A control fields
    localparam int DGT_A_EN_BIT = 7;
    localparam int DGT_A_PER_BIT = 6;
    localparam int DGT_A_PSC_LSB = 2;
    localparam logic [7:0] DGT_A_CTRL_MASK = 8'hcc;
    // Prescaler terminal values (divide minus one)
    localparam logic [14:0] DGT_DIV1 = 15'h0000;
    localparam logic [14:0] DGT_DIV16 = 15'h000f;
    localparam logic [14:0] DGT_DIV256 = 15'h00ff;
    localparam logic [14:0] DGT_DIV32768 = 15'h7fff;
    // Timer A prescale codes
    localparam logic [1:0] DGT_A_PSC16 = 2'h1;
    localparam logic [1:0] DGT_A_PSC256 = 2'h2;
    // Timer B prescale codes
    localparam logic [3:0] DGT_B_PSC16 = 4'h4;
    localparam logic [3:0] DGT_B_PSC256 = 4'h8;
    localparam logic [3:0] DGT_B_PSC32768 = 4'hf;
    // Timer B clock sources
    localparam logic [2:0] DGT_SRC_CORE = 3'h0;
    localparam logic [2:0] DGT_SRC_XTAL = 3'h1;
    localparam logic [2:0] DGT_SRC_GPIO_A = 3'h2;
    localparam logic [2:0] DGT_SRC_GPIO_B = 3'h3;
    // Timer B count formats
    localparam logic [1:0] DGT_FMT_HMS23 = 2'h2;
    localparam logic [1:0] DGT_FMT_HMS255 = 2'h3;
    localparam logic [7:0] DGT_HOUR_MAX23 = 8'h17;
    localparam logic [7:0] DGT_HOUR_MAX255 = 8'hff;
    localparam logic [7:0] DGT_MIN_MAX = 8'h3b;
    localparam logic [7:0] DGT_HUND_MAX = 8'h63;
    // Event numbering offset between select field and source index
    localparam logic [5:0] DGT_EVT_OFFSET = 6'h02;
    // AXI responses
    localparam logic [1:0] DGT_RESP_OKAY = 2'h0;
    localparam logic [1:0] DGT_RESP_SLVERR = 2'h2;
    // Timer B control layout, bit 17 down to bit 0
    typedef struct packed {
        logic cap_en;
        logic [4:0] evt_sel;
        logic [2:0] clk_sel;
        logic up;
        logic en;
        logic periodic;
        logic [1:0] fmt;
        logic [3:0] psc;
    } dgt_b_ctrl_s;
endpackage

/* rtl/dgt_timer.sv */
// Dual general timer with AXI4-Lite register slave
//
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/100ps
module dgt_timer
    import dgt_pkg::*;
(
    // Clock and reset
    input wire logic CLK,
    input wire logic SRST,
    // AXI4-Lite write address
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_AWADDR,
    input wire logic [2:0] S_AXI_AWPROT,
    // AXI4-Lite write data
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    // AXI4-Lite write response
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    output logic [1:0] S_AXI_BRESP,
    // AXI4-Lite read address
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    input wire logic [31:0] S_AXI_ARADDR,
    input wire logic [2:0] S_AXI_ARPROT,
    // AXI4-Lite read data
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    // External clock sources, asynchronous
    input wire logic XTAL_CLK_IN,
    input wire logic GPIO_EDGE_INPUT_A,
    input wire logic GPIO_EDGE_INPUT_B,
    // Interrupt sources for capture, same clock
    input wire logic [33:0] IRQ_SOURCES,
    // Timer outputs
    output logic TIMER_A_IRQ,
    output logic TIMER_B_IRQ,
    output logic ADC_START
);
    // Control and data registers
    logic [15:0] load_a; // Timer A reload value
    logic [15:0] cnt_a; // Timer A live count
    logic [7:0] ctrl_a; // Timer A control, reserved bits zero
    logic [31:0] load_b; // Timer B reload value
    logic [31:0] cnt_b; // Timer B live count
    dgt_b_ctrl_s ctrl_b; // Timer B control
    logic [31:0] cap_b; // Timer B capture
    // Prescalers
    logic [14:0] psc_a; // Timer A prescale count
    logic [14:0] psc_b; // Timer B prescale count
    logic [14:0] div_a; // Timer A terminal
    logic [14:0] div_b; // Timer B terminal
    logic tick_a; // Timer A count step
    logic tick_b; // Timer B count step
    logic src_b; // Timer B source tick
    // Synchronisers: crystal, gpio a, gpio b
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic [2:0] sync3;
    // Event edge detect
    logic evt_now; // Selected source level
    logic evt_prev; // Previous level
    // Terminal detection
    logic term_a;
    logic term_b;
    logic [31:0] full_b; // Full scale for current format
    logic [7:0] hmax; // Hour limit
    logic [31:0] next_cnt_b;
    // Bus state
    logic aw_held;
    logic w_held;
    logic [31:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic [31:0] wr_addr; // Address of write being done
    logic [31:0] wr_data; // Data of write being done
    logic [31:0] wr_mask; // Byte lane mask
    logic do_write;
    logic wr_hit; // Write address mapped
    logic clr_a; // Write to A clear
    logic clr_b; // Write to B clear
    logic [31:0] rd_data;
    logic rd_hit;

    // Increment in hours:minutes:seconds:hundredths, caller excludes full scale
    function automatic logic [31:0] hms_inc(input logic [31:0] v);
        logic [31:0] r;
        r = v;
        if (v[7:0] < DGT_HUND_MAX) begin
            r[7:0] = v[7:0] + 8'h01;
        end else begin
            r[7:0] = 8'h00;
            if (v[15:8] < DGT_MIN_MAX) begin
                r[15:8] = v[15:8] + 8'h01;
            end else begin
                r[15:8] = 8'h00;
                if (v[23:16] < DGT_MIN_MAX) begin
                    r[23:16] = v[23:16] + 8'h01;
                end else begin
                    r[23:16] = 8'h00;
                    r[31:24] = v[31:24] + 8'h01;
                end
            end
        end
        return r;
    endfunction

    // Decrement in hours:minutes:seconds:hundredths, caller excludes zero
    function automatic logic [31:0] hms_dec(input logic [31:0] v);
        logic [31:0] r;
        r = v;
        if (v[7:0] != 8'h00) begin
            r[7:0] = v[7:0] - 8'h01;
        end else begin
            r[7:0] = DGT_HUND_MAX;
            if (v[15:8] != 8'h00) begin
                r[15:8] = v[15:8] - 8'h01;
            end else begin
                r[15:8] = DGT_MIN_MAX;
                if (v[23:16] != 8'h00) begin
                    r[23:16] = v[23:16] - 8'h01;
                end else begin
                    r[23:16] = DGT_MIN_MAX;
                    r[31:24] = v[31:24] - 8'h01;
                end
            end
        end
        return r;
    endfunction

    // two-stage synchronisers
    // First stage feeds only the second; edges are taken on stages two and three
    always_ff @(posedge CLK) begin
        if (SRST) begin
            sync1 <= 3'h0;
            sync2 <= 3'h0;
            sync3 <= 3'h0;
        end else begin
            sync1 <= {GPIO_EDGE_INPUT_B, GPIO_EDGE_INPUT_A, XTAL_CLK_IN};
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    // timer A divide select, code 11 falls to divide by one
    always_comb begin
        unique case (ctrl_a[DGT_A_PSC_LSB +: 2])
            DGT_A_PSC16: div_a = DGT_DIV16;
            DGT_A_PSC256: div_a = DGT_DIV256;
            default: div_a = DGT_DIV1;
        endcase
    end

    always_comb begin
        unique case (ctrl_b.psc)
            DGT_B_PSC16: div_b = DGT_DIV16;
            DGT_B_PSC256: div_b = DGT_DIV256;
            DGT_B_PSC32768: div_b = DGT_DIV32768;
            default: div_b = DGT_DIV1;
        endcase
    end

    // source tick, unlisted selects fall back to core clock
    always_comb begin
        unique case (ctrl_b.clk_sel)
            DGT_SRC_XTAL: src_b = sync2[0] & ~sync3[0];
            DGT_SRC_GPIO_A: src_b = sync2[1] & ~sync3[1];
            DGT_SRC_GPIO_B: src_b = sync2[2] & ~sync3[2];
            default: src_b = 1'b1;
        endcase
    end

    // timer A steps on prescaled core clock
    assign tick_a = ctrl_a[DGT_A_EN_BIT] && (psc_a == div_a);
    assign tick_b = ctrl_b.en && src_b && (psc_b == div_b);

    always_ff @(posedge CLK) begin
        if (SRST || !ctrl_a[DGT_A_EN_BIT] || tick_a) begin
            psc_a <= 15'h0000;
        end else begin
            psc_a <= psc_a + 15'h0001;
        end
    end

    // Timer B prescaler advances on source ticks only
    always_ff @(posedge CLK) begin
        if (SRST || !ctrl_b.en || tick_b) begin
            psc_b <= 15'h0000;
        end else if (src_b) begin
            psc_b <= psc_b + 15'h0001;
        end
    end

    // Terminal values
    assign term_a = (cnt_a == 16'h0000);
    assign hmax = (ctrl_b.fmt == DGT_FMT_HMS23) ? DGT_HOUR_MAX23 : DGT_HOUR_MAX255;
    // format 00 and reserved 01 are plain binary
    assign full_b = ctrl_b.fmt[1] ? {hmax, DGT_MIN_MAX, DGT_MIN_MAX, DGT_HUND_MAX} : 32'hffffffff;
    assign term_b = ctrl_b.up ? (cnt_b == full_b) : (cnt_b == 32'h00000000);

    // Timer A counter
    always_ff @(posedge CLK) begin
        if (SRST) begin
            cnt_a <= DGT_A_COUNT_RST;
        end else if (tick_a) begin
            if (term_a && ctrl_a[DGT_A_PER_BIT]) begin
                cnt_a <= load_a;
            end else begin
                cnt_a <= cnt_a - 16'h0001;
            end
        end
    end

    // Timer B next count
    always_comb begin
        if (term_b) begin
            // reload, else wrap to opposite end
            if (ctrl_b.periodic) begin
                next_cnt_b = load_b;
            end else begin
                next_cnt_b = ctrl_b.up ? 32'h00000000 : full_b;
            end
        end else if (ctrl_b.up) begin
            next_cnt_b = ctrl_b.fmt[1] ? hms_inc(cnt_b) : cnt_b + 32'h00000001;
        end else begin
            next_cnt_b = ctrl_b.fmt[1] ? hms_dec(cnt_b) : cnt_b - 32'h00000001;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            cnt_b <= DGT_B_COUNT_RST;
        end else if (tick_b) begin
            cnt_b <= next_cnt_b;
        end
    end

    // interrupt flags, a terminal step wins over a clear
    always_ff @(posedge CLK) begin
        if (SRST) begin
            TIMER_A_IRQ <= 1'b0;
            TIMER_B_IRQ <= 1'b0;
        end else begin
            TIMER_A_IRQ <= (tick_a && term_a) || (TIMER_A_IRQ && !clr_a);
            TIMER_B_IRQ <= (tick_b && term_b) || (TIMER_B_IRQ && !clr_b);
        end
    end

    // one-cycle conversion start on each timer B terminal step
    always_ff @(posedge CLK) begin
        if (SRST) begin
            ADC_START <= 1'b0;
        end else begin
            ADC_START <= tick_b && term_b;
        end
    end

    // select n picks source n plus two
    assign evt_now = IRQ_SOURCES[{1'b0, ctrl_b.evt_sel} + DGT_EVT_OFFSET];

    // Event level history for rising edge
    always_ff @(posedge CLK) begin
        if (SRST) begin
            evt_prev <= 1'b0;
        end else begin
            evt_prev <= evt_now;
        end
    end

    // capture on each rising edge when enabled
    always_ff @(posedge CLK) begin
        if (SRST) begin
            cap_b <= 32'h00000000;
        end else if (ctrl_b.cap_en && evt_now && !evt_prev) begin
            cap_b <= cnt_b;
        end
    end

    // Write channel acceptance, both halves may arrive in either order
    assign S_AXI_AWREADY = !aw_held && !S_AXI_BVALID;
    assign S_AXI_WREADY = !w_held && !S_AXI_BVALID;
    assign wr_addr = aw_held ? aw_addr : S_AXI_AWADDR;
    assign wr_data = w_held ? w_data : S_AXI_WDATA;
    assign do_write = (aw_held || (S_AXI_AWVALID && S_AXI_AWREADY))
        && (w_held || (S_AXI_WVALID && S_AXI_WREADY));
    assign wr_mask = w_held ? {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}}
        : {{8{S_AXI_WSTRB[3]}}, {8{S_AXI_WSTRB[2]}}, {8{S_AXI_WSTRB[1]}}, {8{S_AXI_WSTRB[0]}}};
    assign clr_a = do_write && (wr_addr == DGT_A_CLR_ADDR);
    assign clr_b = do_write && (wr_addr == DGT_B_CLR_ADDR);
    // Read-only registers accept writes silently
    assign wr_hit = (wr_addr == DGT_A_LOAD_ADDR) || (wr_addr == DGT_A_COUNT_ADDR)
        || (wr_addr == DGT_A_CTRL_ADDR) || (wr_addr == DGT_A_CLR_ADDR)
        || (wr_addr == DGT_B_LOAD_ADDR) || (wr_addr == DGT_B_COUNT_ADDR)
        || (wr_addr == DGT_B_CTRL_ADDR) || (wr_addr == DGT_B_CLR_ADDR)
        || (wr_addr == DGT_B_CAP_ADDR);

    // Holding of one half while the other is awaited
    always_ff @(posedge CLK) begin
        if (SRST || do_write) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
        end else begin
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_held <= 1'b1;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_held <= 1'b1;
            end
        end
    end

    // Captured payloads
    always_ff @(posedge CLK) begin
        if (SRST) begin
            aw_addr <= 32'h00000000;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
        end else begin
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_addr <= S_AXI_AWADDR;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_data <= S_AXI_WDATA;
                w_strb <= S_AXI_WSTRB;
            end
        end
    end

    // Write response
    always_ff @(posedge CLK) begin
        if (SRST) begin
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= DGT_RESP_OKAY;
        end else if (do_write) begin
            S_AXI_BVALID <= 1'b1;
            S_AXI_BRESP <= wr_hit ? DGT_RESP_OKAY : DGT_RESP_SLVERR;
        end else if (S_AXI_BREADY) begin
            S_AXI_BVALID <= 1'b0;
        end
    end

    // Software-written registers, byte lanes honoured
    always_ff @(posedge CLK) begin
        if (SRST) begin
            load_a <= DGT_A_LOAD_RST;
            load_b <= DGT_B_LOAD_RST;
            ctrl_a <= 8'h00;
            ctrl_b <= '0;
        end else if (do_write) begin
            if (wr_addr == DGT_A_LOAD_ADDR) begin
                load_a <= (load_a & ~wr_mask[15:0]) | (wr_data[15:0] & wr_mask[15:0]);
            end
            if (wr_addr == DGT_A_CTRL_ADDR) begin
                ctrl_a <= ((ctrl_a & ~wr_mask[7:0]) | (wr_data[7:0] & wr_mask[7:0])) & DGT_A_CTRL_MASK;
            end
            if (wr_addr == DGT_B_LOAD_ADDR) begin
                load_b <= (load_b & ~wr_mask) | (wr_data & wr_mask);
            end
            if (wr_addr == DGT_B_CTRL_ADDR) begin
                ctrl_b <= (ctrl_b & ~wr_mask[17:0]) | (wr_data[17:0] & wr_mask[17:0]);
            end
        end
    end

    // Read mux, count registers return live state
    always_comb begin
        rd_hit = 1'b1;
        unique case (S_AXI_ARADDR)
            DGT_A_LOAD_ADDR: rd_data = {16'h0000, load_a};
            DGT_A_COUNT_ADDR: rd_data = {16'h0000, cnt_a};
            DGT_A_CTRL_ADDR: rd_data = {24'h000000, ctrl_a};
            DGT_B_LOAD_ADDR: rd_data = load_b;
            DGT_B_COUNT_ADDR: rd_data = cnt_b;
            DGT_B_CTRL_ADDR: rd_data = {14'h0000, ctrl_b};
            DGT_B_CAP_ADDR: rd_data = cap_b;
            // Clear registers are write-only and read zero
            DGT_A_CLR_ADDR, DGT_B_CLR_ADDR: rd_data = 32'h00000000;
            default: begin
                rd_data = 32'h00000000;
                rd_hit = 1'b0;
            end
        endcase
    end

    // Read channel, one read outstanding
    assign S_AXI_ARREADY = !S_AXI_RVALID;
    always_ff @(posedge CLK) begin
        if (SRST) begin
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA <= 32'h00000000;
            S_AXI_RRESP <= DGT_RESP_OKAY;
        end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            S_AXI_RVALID <= 1'b1;
            S_AXI_RDATA <= rd_data;
            S_AXI_RRESP <= rd_hit ? DGT_RESP_OKAY : DGT_RESP_SLVERR;
        end else if (S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
        end
    end

    // Checks
    default clocking dgt_cb @(posedge CLK); endclocking
    default disable iff (SRST);

    AST_A_IRQ_SET: assert property (tick_a && term_a |=> TIMER_A_IRQ)
        else $error("Timer A terminal step did not raise interrupt");
    AST_A_RELOAD: assert property (tick_a && term_a && ctrl_a[DGT_A_PER_BIT] |=> cnt_a == $past(load_a))
        else $error("Timer A periodic reload wrong");
    AST_A_WRAP: assert property (tick_a && term_a && !ctrl_a[DGT_A_PER_BIT] |=> cnt_a == 16'hffff)
        else $error("Timer A free-run wrap wrong");
    AST_A_HOLD: assert property (!ctrl_a[DGT_A_EN_BIT] ##1 !ctrl_a[DGT_A_EN_BIT] |-> $stable(cnt_a))
        else $error("Timer A moved while disabled");
    AST_A_DIV16: assert property (tick_a && ctrl_a[3:2] == DGT_A_PSC16 |-> $past(psc_a) == 15'h000e)
        else $error("Timer A divide by 16 spacing wrong");
    AST_A_CLR: assert property (clr_a && !(tick_a && term_a) |=> !TIMER_A_IRQ)
        else $error("Timer A interrupt not cleared");
    AST_B_CLR: assert property (clr_b && !(tick_b && term_b) |=> !TIMER_B_IRQ)
        else $error("Timer B interrupt not cleared");
    AST_B_UP: assert property (tick_b && ctrl_b.up && !ctrl_b.fmt[1] && !term_b |=> cnt_b == $past(cnt_b) + 32'h1)
        else $error("Timer B up count step wrong");
    AST_B_CAPTURE: assert property (ctrl_b.cap_en && evt_now && !evt_prev |=> cap_b == $past(cnt_b))
        else $error("Timer B capture missed");
    // Back-to-back terminal steps are legal, so the pulse end is checked on its own
    AST_B_ADC: assert property (tick_b && term_b |=> ADC_START && TIMER_B_IRQ)
        else $error("Conversion start pulse missing");
    AST_B_ADC_IDLE: assert property (!(tick_b && term_b) |=> !ADC_START)
        else $error("Conversion start without terminal step");
    AST_B_HMS: assert property (tick_b && ctrl_b.fmt[1] && !term_b |=> cnt_b[7:0] <= DGT_HUND_MAX)
        else $error("Hundredths field out of range");
    AST_BUS_B: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
        else $error("Write response dropped before taken");

    COV_A_PERIODIC: cover property (tick_a && term_a && ctrl_a[DGT_A_PER_BIT]);
    COV_B_CAPTURE: cover property (ctrl_b.cap_en && evt_now && !evt_prev);
    COV_B_HMS_WRAP: cover property (tick_b && term_b && ctrl_b.fmt[1] && ctrl_b.up);
    COV_B_GPIO: cover property (tick_b && ctrl_b.clk_sel == DGT_SRC_GPIO_A);
endmodule

/* tb/testbench.sv */
// Self-checking bench for the dual general timer
`timescale 1ns/100ps
module testbench;
    import dgt_pkg::*;
    // Bench-driven inputs
    logic CLK = 0, SRST = 1, awv = 0, wv = 0, arv = 0;
    logic [31:0] awa = 0, wd = 0, ara = 0;
    logic [2:0] ext = 0; // Crystal, edge input a, edge input b
    logic [33:0] irqs = 0;
    // Design outputs
    logic [31:0] rdata;
    logic awr, wrdy, bv, arr, rv, ia, ib, adc;
    logic [1:0] br, rr;
    int mismatches = 0, tests_run = 0, cyc = 0;
    logic [31:0] c0, c1, dl[4];
    localparam logic [31:0] ra[9] = '{DGT_A_LOAD_ADDR, DGT_A_COUNT_ADDR, DGT_A_CTRL_ADDR, DGT_A_CLR_ADDR,
        DGT_B_LOAD_ADDR, DGT_B_COUNT_ADDR, DGT_B_CTRL_ADDR, DGT_B_CLR_ADDR, DGT_B_CAP_ADDR};
    localparam logic [31:0] re[9] = '{0, 32'hffff, 0, 0, 0, 32'h0fffffff, 0, 0, 0};
    localparam logic [3:0] bp[4] = '{4'h0, 4'h1, 4'h4, 4'h8}; // Unlisted code 1 beside the listed ones
    // 40 MHz core clock
    always #12.5 CLK = ~CLK;
    dgt_timer u_dgt_timer (.CLK(CLK), .SRST(SRST), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
        .S_AXI_AWADDR(awa), .S_AXI_AWPROT(3'h0), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy),
        .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hf), .S_AXI_BVALID(bv), .S_AXI_BREADY(1'b1),
        .S_AXI_BRESP(br), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_ARADDR(ara),
        .S_AXI_ARPROT(3'h0), .S_AXI_RVALID(rv), .S_AXI_RREADY(1'b1), .S_AXI_RDATA(rdata),
        .S_AXI_RRESP(rr), .XTAL_CLK_IN(ext[0]), .GPIO_EDGE_INPUT_A(ext[1]),
        .GPIO_EDGE_INPUT_B(ext[2]), .IRQ_SOURCES(irqs), .TIMER_A_IRQ(ia), .TIMER_B_IRQ(ib),
        .ADC_START(adc));
    // Verdict and end of run
    task automatic summarize;
        if (mismatches == 0 && tests_run > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // Compare one value, four-state exact
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Write one word; readies are steady from negedge to the taking edge
    task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er = DGT_RESP_OKAY);
        logic ta, tw, tb;
        logic [1:0] r;
        tb = 0;
        awv <= 1;
        wv <= 1;
        awa <= a;
        wd <= d;
        while (!tb) begin
            @(negedge CLK);
            ta = awv & awr;
            tw = wv & wrdy;
            tb = bv;
            r = br;
            @(posedge CLK);
            if (ta) awv <= 0;
            if (tw) wv <= 0;
        end
        chk(r, er);
    endtask
    // Read one word and its response
    task automatic rd(input logic [31:0] a, output logic [31:0] d, input logic [1:0] er = DGT_RESP_OKAY);
        logic ta, tb;
        logic [1:0] r;
        tb = 0;
        arv <= 1;
        ara <= a;
        while (!tb) begin
            @(negedge CLK);
            ta = arv & arr;
            tb = rv;
            d = rdata;
            r = rr;
            @(posedge CLK);
            if (ta) arv <= 0;
        end
        chk(r, er);
    endtask
    // Run a timer for a fixed window, return distance moved
    task automatic span(input logic [31:0] ca, input logic [31:0] va, input logic [31:0] m,
        output logic [31:0] d);
        logic [31:0] s, e;
        rd(ca - 32'h4, s);
        wr(ca, va);
        repeat (600) @(posedge CLK);
        wr(ca, 32'h0);
        rd(ca - 32'h4, e);
        d = (va[8] ? e - s : s - e) & m;
    endtask
    // Rising edges on one asynchronous clock input
    task automatic pulse(input int i, input int n);
        repeat (n) begin
            ext[i] <= 1;
            repeat (4) @(posedge CLK);
            ext[i] <= 0;
            repeat (4) @(posedge CLK);
        end
    endtask
    // One same-clock interrupt source pulse
    task automatic spike(input int i);
        irqs[i] <= 1;
        repeat (2) @(posedge CLK);
        irqs[i] <= 0;
        repeat (2) @(posedge CLK);
    endtask
    // Hang guard, well above the expected run length
    always @(posedge CLK) begin
        cyc <= cyc + 1;
        if (cyc == 100000) begin
            mismatches++;
            summarize();
        end
    end
    initial begin
        repeat (10) @(posedge CLK);
        SRST <= 0;
        @(posedge CLK);
        // Register reset values
        foreach (ra[i]) begin
            rd(ra[i], c0);
            chk(c0, re[i]);
        end
        // Unmapped place answers with an error
        rd(32'hffff0310, c0, DGT_RESP_SLVERR);
        wr(32'hffff0310, 32'h1, DGT_RESP_SLVERR);
        // Count is read-only, load holds 16 bits
        wr(DGT_A_COUNT_ADDR, 32'h1234);
        rd(DGT_A_COUNT_ADDR, c0);
        chk(c0, 32'hffff);
        wr(DGT_A_LOAD_ADDR, 32'hffffffff);
        rd(DGT_A_LOAD_ADDR, c0);
        chk(c0, 32'hffff);
        wr(DGT_A_LOAD_ADDR, 32'h5);
        // All ones: enable, periodic, code 11 as divide by one
        wr(DGT_A_CTRL_ADDR, 32'hffffffff);
        rd(DGT_A_CTRL_ADDR, c0);
        chk(c0, 32'hcc);
        for (int n = 0; n < 70000 && ia !== 1'b1; n++) @(posedge CLK);
        rd(DGT_A_COUNT_ADDR, c0);
        chk(32'(c0 <= 32'h5), 1);
        wr(DGT_A_CTRL_ADDR, 32'h0);
        chk(ia, 1);
        wr(DGT_A_CLR_ADDR, 32'h0);
        @(posedge CLK);
        chk(ia, 0);
        // Timer A prescale codes, free-running down
        for (int p = 0; p < 4; p++) span(DGT_A_CTRL_ADDR, 32'h80 | (p << 2), 32'hffff, dl[p]);
        chk(dl[1], 37);
        chk(dl[2], 2);
        chk(dl[3], dl[0]);
        chk(32'(dl[0] > 590 && dl[0] < 610), 1);
        // Timer B control fields and reserved bits
        wr(DGT_B_CTRL_ADDR, 32'hffffffff);
        rd(DGT_B_CTRL_ADDR, c0);
        chk(c0, 32'h3ffff);
        wr(DGT_B_CTRL_ADDR, 32'h0);
        // Timer B prescale, counting up on core clock
        for (int p = 0; p < 4; p++) span(DGT_B_CTRL_ADDR, 32'h180 | bp[p], 32'hffffffff, dl[p]);
        chk(dl[2], 37);
        chk(dl[3], 2);
        chk(dl[1], dl[0]);
        chk(32'(dl[0] > 590 && dl[0] < 610), 1);
        // Each source counts only its own edges, down
        for (int s = 1; s < 4; s++) begin
            rd(DGT_B_COUNT_ADDR, c0);
            wr(DGT_B_CTRL_ADDR, 32'h80 | (s << 9));
            for (int j = 0; j < 3; j++) pulse(j, j + 1);
            repeat (6) @(posedge CLK);
            wr(DGT_B_CTRL_ADDR, 32'h0);
            rd(DGT_B_COUNT_ADDR, c1);
            chk(c0 - c1, s);
        end
        // Capture on event select 3, which watches source 5
        wr(DGT_B_CTRL_ADDR, 32'h23000);
        rd(DGT_B_COUNT_ADDR, c0);
        spike(3);
        rd(DGT_B_CAP_ADDR, c1);
        chk(c1, 0);
        spike(5);
        rd(DGT_B_CAP_ADDR, c1);
        chk(c1, c0);
        // Timer B has not reached a terminal value yet
        chk({30'h0, ib, adc}, 0);
        wr(DGT_B_CLR_ADDR, 32'h0);
        // Sum of all timer B steps so far, then clock format up for 602 ticks
        rd(DGT_B_COUNT_ADDR, c0);
        chk(c0, 32'h100004d4);
        wr(DGT_B_CTRL_ADDR, 32'h1a0);
        repeat (600) @(posedge CLK);
        wr(DGT_B_CTRL_ADDR, 32'h0);
        rd(DGT_B_COUNT_ADDR, c1);
        // First tick folds hundredths to zero with a carry, 601 more give six seconds and one
        chk(c1, {c0[31:16], c0[15:8] + 8'h07, 8'h01});
        summarize();
    end
endmodule
